// >>> src/lbml_top.sv
// lifecycle state, boot-mode lock and loader gating
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module lbml_top
   import lbml_pkg::*;
(
   input wire logic SYS_CLK, // 125 MHz clock
   input wire logic RST_B, // async reset, low
   input wire logic [7:0] ADDR, // register byte address
   input wire logic [31:0] WDATA, // register write data
   input wire logic WR_STB, // write strobe
   input wire logic RD_STB, // read strobe
   output logic [31:0] RDATA, // read data, cycle after strobe
   input wire logic OTP_NORMAL, // one-time cell: normal state
   input wire logic OTP_FLASH, // one-time cell: flash boot
   input wire logic OTP_LOCK, // one-time cell: boot locked
   output logic OTP_WR_STB, // program cells from state outputs
   output logic LC_NORMAL, // lifecycle is normal
   output logic BOOT_ROM, // ROM boot selected
   output logic BOOT_FLASH, // flash boot selected
   output logic BOOT_LOCKED, // boot selection frozen
   input wire logic APDU_VALID, // loader command present
   input wire logic [7:0] APDU_INS, // loader instruction
   input wire logic [31:0] APDU_DATA, // loader data, encrypted
   output logic APDU_ACCEPT, // command taken
   output logic APDU_REJECT, // command refused
   output logic LDR_ACTIVE, // bootloader may run
   output logic FLASH_RD_EN, // loader flash read
   output logic FLASH_WR_EN, // loader flash write
   output logic [31:0] FLASH_WDATA, // decrypted flash data
   input wire logic ROM_RD_REQ, // ROM read request
   output logic ROM_RD_GRANT, // ROM read allowed
   output logic ROM_RD_DENY, // ROM read denied
   output logic TEST_FUNC_GO, // start functional test
   output logic TEST_REJECT // test command refused
);
   // ==========================================================
   // state
   logic ready_r;
   logic normal_r;
   logic flash_r;
   logic lock_r;
   logic hide_r;
   logic [31:0] key_r;
   logic [7:0] rej_r;
   logic [31:0] trace_r [TRACE_N];
   logic auth;
   logic pw_bad;

   // ==========================================================
   // bus decode
   wire sel_ctrl = (ADDR == OFS_CTRL);
   wire sel_stat = (ADDR == OFS_STAT);
   wire sel_pass = (ADDR == OFS_PASS);
   wire sel_key = (ADDR == OFS_KEY);
   wire sel_rej = (ADDR == OFS_REJ);
   wire sel_trace = (ADDR[7:TR_BASE_LO] == OFS_TRACE[7:TR_BASE_LO]);
   wire [1:0] tr_idx = ADDR[TR_IDX_HI:TR_IDX_LO];
   wire wr_ok = WR_STB && ready_r;
   wire wr_ctrl = wr_ok && sel_ctrl;
   wire wr_pass = wr_ok && sel_pass;

   // test commands: password, trace write, go-normal, functional test
   wire tcmd_trace = wr_ok && sel_trace;
   wire tcmd_norm = wr_ctrl && WDATA[CB_NORMAL];
   wire tcmd_ftest = wr_ctrl && WDATA[CB_FTEST];
   wire tcmd_any = tcmd_trace || tcmd_norm || tcmd_ftest;
   wire test_open = !normal_r && auth;
   wire tcmd_refuse = (tcmd_any && !test_open) || pw_bad;
   wire trace_we = tcmd_trace && test_open;
   wire go_normal = tcmd_norm && test_open;
   wire ftest_go = tcmd_ftest && test_open;

   // boot selection moves only toward flash and only while unlocked
   wire set_flash = wr_ctrl && WDATA[CB_FLASH] && !lock_r;
   wire set_lock = wr_ctrl && WDATA[CB_LOCK] && (flash_r || set_flash) && !lock_r;
   wire set_hide = wr_ctrl && WDATA[CB_HIDE];
   wire state_chg = go_normal || (set_flash && !flash_r) || set_lock;

   // loader gating
   wire apdu_in = APDU_VALID && ready_r;
   wire apdu_ok = apdu_in && !flash_r;
   wire apdu_fl = (APDU_INS == INS_FL_READ) || (APDU_INS == INS_FL_WRITE);
   wire fl_blk = flash_r && lock_r;
   wire fl_rd = apdu_ok && !fl_blk && (APDU_INS == INS_FL_READ);
   wire fl_wr = apdu_ok && !fl_blk && (APDU_INS == INS_FL_WRITE);
   wire rom_in = ROM_RD_REQ && ready_r;

   // read mux, unmapped addresses read zero
   logic [31:0] stat_w;
   logic [31:0] rd_mux;
   always_comb begin
      stat_w = WORD_RST;
      stat_w[SB_NORMAL] = normal_r;
      stat_w[SB_AUTH] = auth;
      stat_w[SB_FLASH] = flash_r;
      stat_w[SB_LOCK] = lock_r;
      stat_w[SB_HIDE] = hide_r;
      stat_w[SB_READY] = ready_r;
   end
   // password and key are write-only so they never leak back out
   assign rd_mux = sel_stat ? stat_w :
                   sel_rej ? {24'h000000, rej_r} :
                   sel_trace ? trace_r[tr_idx] : WORD_RST;

   // ==========================================================
   // submodules
   lbml_auth u_auth (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .pw_we(wr_pass),
      .pw_data(WDATA),
      .in_normal(normal_r),
      .auth(auth),
      .pw_bad(pw_bad)
   );

   lbml_dec u_dec (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .in_we(fl_wr),
      .in_data(APDU_DATA),
      .key(key_r),
      .out_we(FLASH_WR_EN),
      .out_data(FLASH_WDATA)
   );

   // ==========================================================
   // one-time cells caught at the first edge after release
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ready_r <= 1'b0;
         normal_r <= 1'b0;
         flash_r <= 1'b0;
         lock_r <= 1'b0;
      end else if (!ready_r) begin
         ready_r <= 1'b1;
         normal_r <= OTP_NORMAL;
         flash_r <= OTP_FLASH || OTP_LOCK;
         lock_r <= OTP_LOCK;
      end else begin
         normal_r <= normal_r || go_normal;
         flash_r <= flash_r || set_flash;
         lock_r <= lock_r || set_lock;
      end
   end

   // hide and key: software controls, hide is one-way
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         hide_r <= 1'b0;
         key_r <= WORD_RST;
      end else begin
         hide_r <= hide_r || set_hide;
         if (wr_ok && sel_key) begin
            key_r <= WDATA;
         end
      end
   end

   // traceability words, writable only while the test door is open
   generate
      for (genvar i = 0; i < TRACE_N; i++) begin : g_trace
         always_ff @(posedge SYS_CLK or negedge RST_B) begin
            if (!RST_B) begin
               trace_r[i] <= WORD_RST;
            end else if (trace_we && (tr_idx == 2'(i))) begin
               trace_r[i] <= WDATA;
            end
         end
      end
   endgenerate

   // refusal counter saturates so it never wraps back to a clean look
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rej_r <= REJ_RST;
      end else if ((tcmd_refuse || (apdu_in && !apdu_ok)) && (rej_r != 8'hff)) begin
         rej_r <= rej_r + REJ_ONE;
      end
   end

   // ==========================================================
   // registered outputs
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         RDATA <= WORD_RST;
         OTP_WR_STB <= 1'b0;
         APDU_ACCEPT <= 1'b0;
         APDU_REJECT <= 1'b0;
         FLASH_RD_EN <= 1'b0;
         ROM_RD_GRANT <= 1'b0;
         ROM_RD_DENY <= 1'b0;
         TEST_FUNC_GO <= 1'b0;
         TEST_REJECT <= 1'b0;
      end else begin
         RDATA <= (RD_STB && ready_r) ? rd_mux : WORD_RST;
         OTP_WR_STB <= state_chg;
         APDU_ACCEPT <= apdu_ok && !(apdu_fl && fl_blk);
         APDU_REJECT <= apdu_in && !(apdu_ok && !(apdu_fl && fl_blk));
         FLASH_RD_EN <= fl_rd;
         ROM_RD_GRANT <= rom_in && !hide_r;
         ROM_RD_DENY <= rom_in && hide_r;
         TEST_FUNC_GO <= ftest_go;
         TEST_REJECT <= tcmd_refuse;
      end
   end

   // state mirrors, one flop each so outputs stay glitch free
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         LC_NORMAL <= 1'b0;
         BOOT_ROM <= 1'b1;
         BOOT_FLASH <= 1'b0;
         BOOT_LOCKED <= 1'b0;
         LDR_ACTIVE <= 1'b0;
      end else begin
         LC_NORMAL <= normal_r;
         BOOT_ROM <= !flash_r;
         BOOT_FLASH <= flash_r;
         BOOT_LOCKED <= lock_r;
         LDR_ACTIVE <= ready_r && !flash_r;
      end
   end

   // ==========================================================
   // checks
   AST_NORMAL_KEPT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (ready_r && normal_r) |=> normal_r)
      else $error("normal state was left");
   AST_NO_AUTH_NO_TRACE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (tcmd_trace && !auth) |=> ($stable(trace_r[0]) && TEST_REJECT))
      else $error("trace write without password");
   AST_TRACE_FROZEN: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (normal_r && wr_ok && sel_trace) |=> ($stable(trace_r[0]) && $stable(trace_r[1]) &&
      $stable(trace_r[2]) && $stable(trace_r[3])))
      else $error("trace changed in normal state");
   AST_TEST_REFUSED: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (normal_r && tcmd_any) |=> (TEST_REJECT && !TEST_FUNC_GO))
      else $error("test command taken in normal state");
   AST_FTEST_IN_TEST: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      TEST_FUNC_GO |-> (!$past(normal_r) && $past(tcmd_ftest)))
      else $error("functional test outside test state");
   AST_BOOT_ONE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      BOOT_ROM != BOOT_FLASH)
      else $error("boot domains not exclusive");
   AST_LOCK_HELD: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (ready_r && lock_r) |=> (lock_r && flash_r) [*3])
      else $error("locked boot selection moved");
   AST_LDR_OFF: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (ready_r && flash_r) |=> !LDR_ACTIVE)
      else $error("loader active in flash boot");
   AST_APDU_FLASH: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (apdu_in && flash_r) |=> (APDU_REJECT && !APDU_ACCEPT && !FLASH_WR_EN))
      else $error("loader command taken in flash boot");
   AST_FL_BLOCK: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (FLASH_RD_EN || FLASH_WR_EN) |-> !$past(lock_r))
      else $error("flash access while locked");
   AST_ROM_HIDE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (rom_in && hide_r) |=> (ROM_RD_DENY && !ROM_RD_GRANT))
      else $error("hidden ROM read granted");
   AST_DECRYPT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      fl_wr |=> (FLASH_WR_EN && FLASH_WDATA == ($past(APDU_DATA) ^ $past(key_r))))
      else $error("flash data not decrypted");
   AST_SAMPLE_FIRST: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      (RST_B && !ready_r) |=> (!APDU_ACCEPT && !APDU_REJECT && !TEST_FUNC_GO && ready_r))
      else $error("request taken before cells sampled");
endmodule

// >>> src/lbml_pkg.sv
// constants for the lifecycle and boot-mode lock block
// How it works
// - one switch leaves the test state for the normal state, and nothing ever brings it back.
// - test functions open only after the tester writes the right password, other tries are refused.
// - in the test state an authenticated tester may write the traceability words.
// - in the normal state the traceability words stay readable and every write to them is dropped.
// - every test command arriving in the normal state is refused.
// - the manufacturing functional test starts only in the test state.
// - exactly one of ROM boot and flash boot is selected at any time.
// - the boot selection may move from ROM to flash and may then be locked there.
// - once locked in flash boot, no further change of the boot selection is taken.
// - the bootloader is active only in ROM boot.
// - bootloader APDU commands are accepted only in ROM boot and rejected in flash boot.
// - locked in flash boot, the loader's flash read and write commands are blocked.
// - a one-way hide control makes ROM inaccessible and later ROM reads are denied.
// - flash data from the host arrives encrypted and is decrypted before it is stored.
// - all control registers take defined values at reset.
package lbml_pkg;
   // =========================================================
   // register bus
   localparam int LBML_AW = 8;
   localparam int LBML_DW = 32;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_PASS = 8'h08;
   localparam logic [7:0] OFS_KEY = 8'h0c;
   localparam logic [7:0] OFS_REJ = 8'h10;
   localparam logic [7:0] OFS_TRACE = 8'h20;
   localparam int TR_IDX_LO = 2;
   localparam int TR_IDX_HI = 3;
   localparam int TR_BASE_LO = 4;
   localparam int TRACE_N = 4;
   // =========================================================
   // control and status bit positions
   localparam int CB_NORMAL = 0;
   localparam int CB_FLASH = 1;
   localparam int CB_LOCK = 2;
   localparam int CB_HIDE = 3;
   localparam int CB_FTEST = 4;
   localparam int SB_NORMAL = 0;
   localparam int SB_AUTH = 1;
   localparam int SB_FLASH = 2;
   localparam int SB_LOCK = 3;
   localparam int SB_HIDE = 4;
   localparam int SB_READY = 5;
   // =========================================================
   // reset values and codes
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [7:0] REJ_RST = 8'h00;
   localparam logic [7:0] REJ_ONE = 8'h01;
   // arbitrary value, replaced per product
   localparam logic [31:0] TEST_PASSWORD = 32'h5a3c_96e1;
   localparam logic [7:0] INS_FL_READ = 8'hb0;
   localparam logic [7:0] INS_FL_WRITE = 8'hd6;
endpackage

// >>> src/lbml_auth.sv
// password check for tester access
`timescale 1ns/1ps
module lbml_auth
   import lbml_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, low
   input wire logic pw_we, // password word offered
   input wire logic [31:0] pw_data, // offered password
   input wire logic in_normal, // normal state, no access
   output logic auth, // tester authenticated
   output logic pw_bad // offered word is wrong, or offered in the normal state
);
   // a wrong try also drops an earlier grant, so guessing costs the session
   assign pw_bad = pw_we && (in_normal || (pw_data != TEST_PASSWORD));

   // grant held until reset, a bad try or the normal state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         auth <= 1'b0;
      end else if (in_normal) begin
         auth <= 1'b0;
      end else if (pw_we) begin
         auth <= !pw_bad;
      end
   end
endmodule

// >>> src/lbml_dec.sv
// decryption of host flash data on its way to the flash
`timescale 1ns/1ps
module lbml_dec
   import lbml_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, low
   input wire logic in_we, // ciphertext word valid
   input wire logic [31:0] in_data, // ciphertext word
   input wire logic [31:0] key, // session key
   output logic out_we, // plaintext write strobe
   output logic [31:0] out_data // plaintext word
);
   logic [31:0] plain;
   // stand-in keystream; the real cipher core plugs in here with the same timing
   assign plain = in_data ^ key;

   // registered so flash outputs come from flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_we <= 1'b0;
         out_data <= WORD_RST;
      end else begin
         out_we <= in_we;
         out_data <= in_we ? plain : WORD_RST;
      end
   end
endmodule

// >>> test/lbml_otp_model.sv
// one-time cell model standing behind the lifecycle block
`timescale 1ns/1ps
module lbml_otp_model (
   input wire logic clk, // system clock
   input wire logic prog, // program strobe from the block
   input wire logic normal_in, // lifecycle to store
   input wire logic flash_in, // boot choice to store
   input wire logic lock_in, // boot lock to store
   output logic cell_normal, // stored lifecycle
   output logic cell_flash, // stored boot choice
   output logic cell_lock // stored boot lock
);
   logic pend_r;
   // =========================================================
   // blank cells at power-up
   initial begin
      cell_normal = 1'b0;
      cell_flash = 1'b0;
      cell_lock = 1'b0;
      pend_r = 1'b0;
   end
   // =========================================================
   // bits only ever set; reset leaves them, so state survives it
   // also programmed one cycle late, as outputs may lag the strobe
   always @(posedge clk) begin
      pend_r <= prog;
      if (prog || pend_r) begin
         cell_normal <= cell_normal | normal_in;
         cell_flash <= cell_flash | flash_in;
         cell_lock <= cell_lock | lock_in;
      end
   end
endmodule

// >>> test/lbml_top_test.sv
// self-checking bench for the lifecycle and boot-mode lock block
`timescale 1ns/1ps
module lbml_top_test;
   import lbml_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic apdu_valid = 1'b0;
   logic [7:0] apdu_ins = 8'h00;
   logic [31:0] apdu_data = 32'h0000_0000;
   logic rom_rd_req = 1'b0;
   logic [31:0] rdata, fl_wdata, p_fwd, v;
   logic otp_normal, otp_flash, otp_lock, otp_wr_stb, lc_normal, boot_rom, boot_flash;
   logic boot_locked, apdu_accept, apdu_reject, ldr_active, fl_rd_en, fl_wr_en;
   logic rom_grant, rom_deny, test_go, test_rej;
   logic p_rej, p_go, p_acc, p_arej, p_fre, p_fwe, p_gnt, p_deny;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int rej_exp = 0;
   localparam logic [31:0] KEY_VAL = 32'h0f1e_2d3c;
   // =========================================================
   // design and cell model
   lbml_top i_lbml_top (.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
      .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .OTP_NORMAL(otp_normal),
      .OTP_FLASH(otp_flash), .OTP_LOCK(otp_lock), .OTP_WR_STB(otp_wr_stb),
      .LC_NORMAL(lc_normal), .BOOT_ROM(boot_rom), .BOOT_FLASH(boot_flash),
      .BOOT_LOCKED(boot_locked), .APDU_VALID(apdu_valid), .APDU_INS(apdu_ins),
      .APDU_DATA(apdu_data), .APDU_ACCEPT(apdu_accept), .APDU_REJECT(apdu_reject),
      .LDR_ACTIVE(ldr_active), .FLASH_RD_EN(fl_rd_en), .FLASH_WR_EN(fl_wr_en),
      .FLASH_WDATA(fl_wdata), .ROM_RD_REQ(rom_rd_req), .ROM_RD_GRANT(rom_grant),
      .ROM_RD_DENY(rom_deny), .TEST_FUNC_GO(test_go), .TEST_REJECT(test_rej));
   lbml_otp_model i_lbml_otp_model (.clk(sys_clk), .prog(otp_wr_stb), .normal_in(lc_normal),
      .flash_in(boot_flash), .lock_in(boot_locked), .cell_normal(otp_normal),
      .cell_flash(otp_flash), .cell_lock(otp_lock));
   // =========================================================
   // clock and hang guard; ceiling well above the roughly 105 cycles used
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         test_done();
      end
   end
   // =========================================================
   // compares and bus tasks
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk(what, {31'h0, exp}, {31'h0, got});
   endtask
   // pulses come from flops loaded at the taking edge, so grab them just after it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
      #1;
      p_rej = test_rej;
      p_go = test_go;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic apdu(input logic [7:0] ins, input logic [31:0] d);
      @(posedge sys_clk);
      apdu_ins <= ins;
      apdu_data <= d;
      apdu_valid <= 1'b1;
      @(posedge sys_clk);
      apdu_valid <= 1'b0;
      #1;
      p_acc = apdu_accept;
      p_arej = apdu_reject;
      p_fre = fl_rd_en;
      p_fwe = fl_wr_en;
      p_fwd = fl_wdata;
   endtask
   task automatic rom_rd();
      @(posedge sys_clk);
      rom_rd_req <= 1'b1;
      @(posedge sys_clk);
      rom_rd_req <= 1'b0;
      #1;
      p_gnt = rom_grant;
      p_deny = rom_deny;
   endtask
   function automatic logic [31:0] st(input logic n, a, f, l, h);
      st = (32'h1 << SB_READY) | ({31'h0, n} << SB_NORMAL) | ({31'h0, a} << SB_AUTH);
      st = st | ({31'h0, f} << SB_FLASH) | ({31'h0, l} << SB_LOCK) | ({31'h0, h} << SB_HIDE);
   endfunction
   task automatic chk_st(input logic [31:0] exp);
      rd(OFS_STAT, v);
      chk("status", exp, v);
   endtask
   task automatic chk_rej();
      rd(OFS_REJ, v);
      chk("refused count", 32'(rej_exp), v);
   endtask
   task automatic do_reset();
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (7) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   // =========================================================
   // scenarios
   task automatic t_reset();
      chk_bit("boot rom", 1'b1, boot_rom);
      chk_bit("loader", 1'b1, ldr_active);
      chk_st(st(0, 0, 0, 0, 0));
      chk_rej();
   endtask
   task automatic t_auth();
      rd(OFS_TRACE, v);
      chk("trace 0", 32'h0, v);
      wr(OFS_TRACE, 32'h1111_1111);
      chk_bit("shut trace write", 1'b1, p_rej);
      wr(OFS_PASS, TEST_PASSWORD ^ 32'h8000_0001);
      chk_bit("wrong password", 1'b1, p_rej);
      rej_exp += 2;
      chk_st(st(0, 0, 0, 0, 0));
      wr(OFS_PASS, TEST_PASSWORD);
      chk_bit("right password", 1'b0, p_rej);
      chk_st(st(0, 1, 0, 0, 0));
      for (int i = 0; i < TRACE_N; i++) begin
         wr(OFS_TRACE + 8'(4 * i), 32'hc0de_0000 | 32'(i));
         chk_bit("trace write", 1'b0, p_rej);
      end
      for (int i = 0; i < TRACE_N; i++) begin
         rd(OFS_TRACE + 8'(4 * i), v);
         chk("trace word", 32'hc0de_0000 | 32'(i), v);
      end
      chk_rej();
      wr(OFS_CTRL, 32'h1 << CB_FTEST);
      chk_bit("functional test", 1'b1, p_go);
   endtask
   task automatic t_loader();
      wr(OFS_KEY, KEY_VAL);
      apdu(INS_FL_WRITE, 32'h1234_5678);
      chk_bit("write taken", 1'b1, p_acc);
      chk_bit("flash write", 1'b1, p_fwe);
      chk("flash data", 32'h1234_5678 ^ KEY_VAL, p_fwd);
      apdu(INS_FL_READ, 32'h0);
      chk_bit("flash read", 1'b1, p_fre);
      apdu(8'h44, 32'h0);
      chk_bit("other taken", 1'b1, p_acc);
      rom_rd();
      chk_bit("rom grant", 1'b1, p_gnt);
      wr(OFS_CTRL, 32'h1 << CB_HIDE);
      rom_rd();
      chk_bit("rom deny", 1'b1, p_deny);
      chk_bit("rom no grant", 1'b0, p_gnt);
   endtask
   task automatic t_normal();
      wr(OFS_CTRL, 32'h1 << CB_NORMAL);
      chk_st(st(1, 0, 0, 0, 1));
      wr(OFS_TRACE, 32'hdead_beef);
      chk_bit("sealed trace", 1'b1, p_rej);
      rd(OFS_TRACE, v);
      chk("trace kept", 32'hc0de_0000, v);
      wr(OFS_CTRL, 32'h1 << CB_FTEST);
      chk_bit("no functional test", 1'b0, p_go);
      wr(OFS_PASS, TEST_PASSWORD);
      chk_bit("password refused", 1'b1, p_rej);
      rej_exp += 3;
      chk_st(st(1, 0, 0, 0, 1));
      chk_rej();
   endtask
   task automatic t_boot();
      wr(OFS_CTRL, (32'h1 << CB_FLASH) | (32'h1 << CB_LOCK));
      // state mirrors follow the internal state one edge later
      @(posedge sys_clk);
      #1;
      chk_bit("boot rom off", 1'b0, boot_rom);
      chk_bit("locked", 1'b1, boot_locked);
      chk_bit("loader off", 1'b0, ldr_active);
      apdu(INS_FL_WRITE, 32'h1);
      chk_bit("write refused", 1'b1, p_arej);
      chk_bit("no flash write", 1'b0, p_fwe);
      apdu(INS_FL_READ, 32'h1);
      chk_bit("no flash read", 1'b0, p_fre);
      rej_exp += 2;
      wr(OFS_CTRL, 32'h0);
      chk_st(st(1, 0, 1, 1, 1));
      chk_rej();
   endtask
   task automatic t_reboot();
      do_reset();
      rej_exp = 0;
      chk_st(st(1, 0, 1, 1, 0));
      chk_bit("still normal", 1'b1, lc_normal);
      chk_bit("loader stays off", 1'b0, ldr_active);
      apdu(8'h44, 32'h0);
      chk_bit("apdu refused", 1'b1, p_arej);
      rej_exp += 1;
      chk_rej();
   endtask
   // =========================================================
   // main sequence
   initial begin
      do_reset();
      t_reset();
      t_auth();
      t_loader();
      t_normal();
      t_boot();
      t_reboot();
      test_done();
   end
endmodule
